// ===== rtl/reset_sleep_pkg.sv
// Purpose : constants shared by the reset and sleep manager
// Assumes : 32-bit APB data, one aligned word per register
// Notes   : register contents are 8 bits wide in the low byte
package reset_sleep_pkg;
   // ==========================================================
   // register byte addresses
   localparam logic [7:0] ADDR_CONTROL  = 8'h00;
   localparam logic [7:0] ADDR_CAUSE    = 8'h04;
   localparam logic [7:0] ADDR_WATCHDOG = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   // ==========================================================
   // control register fields
   localparam int BIT_SLEEP_UNLOCK = 7;
   localparam int BIT_PCONF_EN     = 6;
   localparam int BIT_ILL_EN       = 5;
   localparam int BIT_WD_EN        = 4;
   // cause register fields
   localparam int BIT_SLEEP_REQ    = 7;
   localparam int BIT_ILL_CAUSE    = 5;
   localparam int BIT_WD_CAUSE     = 4;
   localparam int BIT_COMBO_CAUSE  = 3;
   localparam int BIT_EXT_CAUSE    = 2;
   localparam int BIT_WAKE_CAUSE   = 1;
   localparam logic [7:0] CAUSE_USED_MASK = 8'h3e;
   // interrupt status fields
   localparam int IRQ_W      = 4;
   localparam int IRQ_EXT    = 0;
   localparam int IRQ_COMBO  = 1;
   localparam int IRQ_WD     = 2;
   localparam int IRQ_ILL    = 3;
   // ==========================================================
   // watchdog
   localparam logic [3:0] WD_KEY_FIRST  = 4'ha;
   localparam logic [3:0] WD_KEY_SECOND = 4'h3;
   localparam logic [3:0] WD_LIMIT      = 4'h8;
   localparam logic [3:0] WD_ZERO       = 4'h0;
   localparam logic [3:0] WD_STEP       = 4'h1;
   // key sequencer states
   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b01,
      KEY_ARMED = 2'b10
   } key_state_t;
endpackage : reset_sleep_pkg

// ===== rtl/reset_sleep_manager.sv
// Purpose : reset source merge, cause recording, sleep control, watchdog
// Assumes : nrst_in is the power-up reset; source inputs synchronous to clk_in
// Notes   : APB slave, one wait-free access cycle; unmapped address gives pslverr
//
// Contract
// - control bit 7 unlocks sleep; cold reset
// - control bit 6 gates port configuration reset
// - control bit 5 enables illegal-access source
// - control bit 4 watchdog enable, never cleared by a write
// - cause bit 7 sleep request reads zero
// - cause bit 5 flags illegal-access reset
// - cause bit 4 flags watchdog reset
// - cause bit 3 flags pin-combination reset
// - cause bit 2 flags external pin reset
// - cause bit 1 flags pin reset during sleep
// - watchdog bits 3..0 read the counter
// - merge sources into lines, govern sleep
// - system reset on any enabled source
// - keys 0x0a then 0x03 clear counter
// - enabled watchdog resets at count eight
`timescale 1ns/1ps
module reset_sleep_manager
   import reset_sleep_pkg::*;
(
   // clock and power-up reset
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // reset sources
   input  wire logic        ext_pin_reset_in,
   input  wire logic        pin_combo_reset_in,
   input  wire logic        illegal_access_in,
   input  wire logic        watchdog_tick_in,
   // distributed reset lines
   output logic             cold_reset_out,
   output logic             system_reset_out,
   output logic             port_config_reset_out,
   output logic             sleep_reset_out,
   // interrupt
   output logic             irq_out
);
   // ==========================================================
   // state
   logic             sleep_unlock;
   logic             port_config_reset_enable;
   logic             illegal_access_reset_enable;
   logic             watchdog_reset_enable;
   logic [7:0]       cause_flags;
   logic [7:0]       read_capture;
   logic [3:0]       watchdog_count;
   key_state_t       key_state;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   // ==========================================================
   // bus decode
   logic       bus_setup;
   logic       bus_fire;
   logic       wr_fire;
   logic       rd_fire;
   logic       mapped;
   logic [7:0] next_rdata;
   logic [3:0] watchdog_key;

   assign bus_setup    = psel_in & ~penable_in;
   assign bus_fire     = psel_in & penable_in & pready_out;
   assign wr_fire      = bus_fire & pwrite_in & ~pslverr_out;
   assign rd_fire      = bus_fire & ~pwrite_in & ~pslverr_out;
   assign watchdog_key = pwdata_in[3:0];

   // read mux, unused bits zero
   always_comb
   begin
      mapped     = 1'b1;
      next_rdata = 8'h00;
      case (paddr_in)
         ADDR_CONTROL  : next_rdata = {sleep_unlock, port_config_reset_enable,
                                       illegal_access_reset_enable,
                                       watchdog_reset_enable, 4'h0};
         ADDR_CAUSE    : next_rdata = cause_flags & CAUSE_USED_MASK;
         ADDR_WATCHDOG : next_rdata = {4'h0, watchdog_count};
         ADDR_IRQ_STAT : next_rdata = {4'h0, irq_status};
         ADDR_IRQ_MASK : next_rdata = {4'h0, irq_mask};
         default       : mapped = 1'b0;
      endcase
   end

   // answer one cycle after setup
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         pready_out   <= 1'b0;
         pslverr_out  <= 1'b0;
         prdata_out   <= 32'h0000_0000;
         read_capture <= 8'h00;
      end
      else
      begin
         pready_out  <= bus_setup;
         pslverr_out <= bus_setup & ~mapped;
         if (bus_setup)
         begin
            prdata_out   <= {24'h00_0000, next_rdata};
            read_capture <= next_rdata;
         end
      end
   end

   logic ctrl_wr;
   logic cause_wr;
   logic cause_rd;
   logic wd_wr;
   assign ctrl_wr  = wr_fire & (paddr_in == ADDR_CONTROL);
   assign cause_wr = wr_fire & (paddr_in == ADDR_CAUSE);
   assign cause_rd = rd_fire & (paddr_in == ADDR_CAUSE);
   assign wd_wr    = wr_fire & (paddr_in == ADDR_WATCHDOG);

   // ==========================================================
   // control register, cleared by power-up reset; bits 7..5 also by a write
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sleep_unlock                <= 1'b0;
         port_config_reset_enable    <= 1'b0;
         illegal_access_reset_enable <= 1'b0;
         watchdog_reset_enable       <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         sleep_unlock                <= pwdata_in[BIT_SLEEP_UNLOCK];
         port_config_reset_enable    <= pwdata_in[BIT_PCONF_EN];
         illegal_access_reset_enable <= pwdata_in[BIT_ILL_EN];
         watchdog_reset_enable       <= watchdog_reset_enable | pwdata_in[BIT_WD_EN];
      end
   end

   // ==========================================================
   // source merge
   logic ill_fire;
   logic wd_fire;
   logic sys_src;
   logic service;
   assign ill_fire = illegal_access_reset_enable & illegal_access_in;
   assign wd_fire  = watchdog_reset_enable & (watchdog_count == WD_LIMIT);
   assign sys_src  = ext_pin_reset_in | pin_combo_reset_in | wd_fire | ill_fire;
   assign service  = wd_wr & (key_state == KEY_ARMED) & (watchdog_key == WD_KEY_SECOND);

   // reset lines except sleep, all asserted during power-up reset
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cold_reset_out        <= 1'b1;
         system_reset_out      <= 1'b1;
         port_config_reset_out <= 1'b1;
      end
      else
      begin
         cold_reset_out        <= 1'b0;
         system_reset_out      <= sys_src;
         port_config_reset_out <= sys_src & port_config_reset_enable;
      end
   end

   // sleep entry needs unlock; any system source wakes
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         sleep_reset_out <= 1'b0;
      else if (sys_src)
         sleep_reset_out <= 1'b0;
      else if (cause_wr & pwdata_in[BIT_SLEEP_REQ] & sleep_unlock)
         sleep_reset_out <= 1'b1;
   end

   // ==========================================================
   // cause flags: set wins over read or write clear
   logic [7:0] cause_set;
   logic [7:0] cause_clr;
   always_comb
   begin
      cause_set                  = 8'h00;
      cause_set[BIT_ILL_CAUSE]   = ill_fire;
      cause_set[BIT_WD_CAUSE]    = wd_fire;
      cause_set[BIT_COMBO_CAUSE] = pin_combo_reset_in;
      cause_set[BIT_EXT_CAUSE]   = ext_pin_reset_in;
      cause_set[BIT_WAKE_CAUSE]  = ext_pin_reset_in & sleep_reset_out;
      cause_clr                  = 8'h00;
      if (cause_wr)
         cause_clr = CAUSE_USED_MASK;
      else if (cause_rd)
         cause_clr = read_capture; // clears only what was seen
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         cause_flags <= 8'h00;
      else
         cause_flags <= ((cause_flags & ~cause_clr) | cause_set) & CAUSE_USED_MASK;
   end

   // ==========================================================
   // watchdog key sequencer
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         key_state <= KEY_IDLE;
      else if (wd_wr)
      begin
         case (watchdog_key)
            WD_KEY_FIRST : key_state <= KEY_ARMED;
            default      : key_state <= KEY_IDLE;
         endcase
      end
   end

   // watchdog counter, runs only while enabled
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         watchdog_count <= WD_ZERO;
      else if (service | wd_fire)
         watchdog_count <= WD_ZERO;
      else if (watchdog_reset_enable & watchdog_tick_in & (watchdog_count < WD_LIMIT))
         watchdog_count <= watchdog_count + WD_STEP;
   end

   // ==========================================================
   // interrupts: sticky, write one to clear, set wins
   logic [IRQ_W-1:0] irq_set;
   assign irq_set = {ill_fire, wd_fire, pin_combo_reset_in, ext_pin_reset_in};

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         irq_status <= '0;
         irq_mask   <= '0;
         irq_out    <= 1'b0;
      end
      else
      begin
         if (wr_fire & (paddr_in == ADDR_IRQ_STAT))
            irq_status <= (irq_status & ~pwdata_in[IRQ_W-1:0]) | irq_set;
         else
            irq_status <= irq_status | irq_set;
         if (wr_fire & (paddr_in == ADDR_IRQ_MASK))
            irq_mask <= pwdata_in[IRQ_W-1:0];
         irq_out <= |(irq_status & irq_mask);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_arm;
      wd_wr && (watchdog_key == WD_KEY_FIRST);
   endsequence
   sequence s_serve;
      wd_wr && (watchdog_key == WD_KEY_SECOND) && !wd_fire;
   endsequence

   chk_wd_sticky_en: assert property (
      watchdog_reset_enable |=> watchdog_reset_enable)
      else $error("watchdog enable was cleared");
   chk_sleep_needs_unlock: assert property (
      $rose(sleep_reset_out) |-> $past(cause_wr && pwdata_in[BIT_SLEEP_REQ] && sleep_unlock))
      else $error("sleep entered without unlock");
   chk_sleep_reads_zero: assert property (
      (pready_out && !pwrite_in && paddr_in == ADDR_CAUSE) |-> !prdata_out[BIT_SLEEP_REQ])
      else $error("sleep request read as one");
   // the lines still show their power-up value at the first edge after release
   chk_pconf_gate: assert property (
      port_config_reset_out && !cold_reset_out
      |-> system_reset_out && $past(port_config_reset_enable))
      else $error("port config reset without enable");
   chk_sys_merge: assert property (
      !cold_reset_out |-> system_reset_out == $past(sys_src))
      else $error("system reset does not follow sources");
   chk_wd_timeout: assert property (
      (watchdog_reset_enable && watchdog_count == WD_LIMIT)
      |=> system_reset_out && watchdog_count == WD_ZERO)
      else $error("watchdog limit did not reset");
   // two writes land at least two cycles apart, so no third write fits in between
   chk_wd_service: assert property (
      (s_arm ##[2:3] s_serve) |=> watchdog_count == WD_ZERO)
      else $error("key pair did not clear watchdog");
   chk_wd_count_read: assert property (
      bus_setup && paddr_in == ADDR_WATCHDOG |=> prdata_out == {28'h000_0000, $past(watchdog_count)})
      else $error("watchdog count read wrong");
   chk_cause_set: assert property (
      cause_set != 8'h00 |=> (cause_flags & $past(cause_set)) == $past(cause_set))
      else $error("cause event lost");
   chk_cause_write_clr: assert property (
      (cause_wr && cause_set == 8'h00) |=> cause_flags == 8'h00)
      else $error("cause write did not clear");
   chk_cause_read_clr: assert property (
      (cause_rd && cause_set == 8'h00) |=> (cause_flags & $past(read_capture)) == 8'h00)
      else $error("cause read did not clear");
   chk_irq_level: assert property (
      irq_out == $past(|(irq_status & irq_mask)))
      else $error("interrupt level wrong");
endmodule : reset_sleep_manager

// ===== verification/tb_reset_sleep_manager.sv
// Purpose : self-checking bench for the reset and sleep manager
// Assumes : apb master tasks below; sources driven directly by the bench
// Notes   : sequences of register calls with worked-out expected values
`timescale 1ns/1ps
module tb_reset_sleep_manager
   import reset_sleep_pkg::*;
;
   // ==========================================================
   // signals
   logic        clk_in             = 1'b0;
   logic        nrst_in            = 1'b0;
   logic        psel_in            = 1'b0;
   logic        penable_in         = 1'b0;
   logic        pwrite_in          = 1'b0;
   logic [7:0]  paddr_in           = 8'h00;
   logic [31:0] pwdata_in          = 32'h0;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        ext_pin_reset_in   = 1'b0;
   logic        pin_combo_reset_in = 1'b0;
   logic        illegal_access_in  = 1'b0;
   logic        watchdog_tick_in   = 1'b0;
   logic        cold_reset_out;
   logic        system_reset_out;
   logic        port_config_reset_out;
   logic        sleep_reset_out;
   logic        irq_out;
   int          n_mismatch         = 0;
   int          n_compared         = 0;
   int          cycles             = 0;
   logic [31:0] rdata;
   logic        rerr;
   // ==========================================================
   // design under test
   reset_sleep_manager dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .ext_pin_reset_in(ext_pin_reset_in),
      .pin_combo_reset_in(pin_combo_reset_in), .illegal_access_in(illegal_access_in),
      .watchdog_tick_in(watchdog_tick_in), .cold_reset_out(cold_reset_out),
      .system_reset_out(system_reset_out), .port_config_reset_out(port_config_reset_out),
      .sleep_reset_out(sleep_reset_out), .irq_out(irq_out));
   // 50 mhz clock
   always #10 clk_in = ~clk_in;
   // hang guard on a cycle count
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   // ==========================================================
   // tasks
   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t value seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one apb transfer: setup, access until pready, then release
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge clk_in);
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= wr;
      paddr_in   <= addr;
      pwdata_in  <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      // only the cycle guard ends a wait for pready
      do
      begin
         @(posedge clk_in);
      end
      while (pready_out !== 1'b1);
      rdata      = prdata_out;
      rerr       = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
      xfer(1'b1, addr, wd);
   endtask : wr
   task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
      xfer(1'b0, addr, 32'h0);
      check(rdata, exp);
   endtask : rd
   // one-cycle source pulse, then the reset lines one cycle later
   task automatic pulse(input int src, input logic exp_sys, input logic exp_pconf);
      @(posedge clk_in);
      case (src)
         0: ext_pin_reset_in <= 1'b1;
         1: pin_combo_reset_in <= 1'b1;
         default: illegal_access_in <= 1'b1;
      endcase
      @(posedge clk_in);
      ext_pin_reset_in   <= 1'b0;
      pin_combo_reset_in <= 1'b0;
      illegal_access_in  <= 1'b0;
      #1;
      check(32'(system_reset_out), 32'(exp_sys));
      check(32'(port_config_reset_out), 32'(exp_pconf));
   endtask : pulse
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clk_in);
         watchdog_tick_in <= 1'b1;
         @(posedge clk_in);
         watchdog_tick_in <= 1'b0;
      end
   endtask : tick
   task automatic settle();
      repeat (2) @(posedge clk_in);
      #1;
   endtask : settle
   // ==========================================================
   // main sequence
   initial
   begin
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      rd(ADDR_CONTROL, 32'h0);
      rd(ADDR_CAUSE, 32'h0);
      rd(ADDR_WATCHDOG, 32'h0);
      rd(ADDR_IRQ_STAT, 32'h0);
      rd(ADDR_IRQ_MASK, 32'h0);
      rd(8'h14, 32'h0);
      check(32'(rerr), 32'h1);
      check(32'(cold_reset_out), 32'h0);
      pulse(0, 1'b1, 1'b0);
      rd(ADDR_CAUSE, 32'h04);
      rd(ADDR_CAUSE, 32'h0);
      pulse(2, 1'b0, 1'b0);
      rd(ADDR_CAUSE, 32'h0);
      wr(ADDR_CONTROL, 32'h60);
      rd(ADDR_CONTROL, 32'h60);
      pulse(2, 1'b1, 1'b1);
      pulse(1, 1'b1, 1'b1);
      rd(ADDR_CAUSE, 32'h28);
      pulse(0, 1'b1, 1'b1);
      wr(ADDR_CAUSE, 32'h0);
      rd(ADDR_CAUSE, 32'h0);
      // sleep entry is locked, then unlocked
      wr(ADDR_CAUSE, 32'h80);
      settle();
      check(32'(sleep_reset_out), 32'h0);
      wr(ADDR_CONTROL, 32'he0);
      wr(ADDR_CAUSE, 32'h80);
      settle();
      check(32'(sleep_reset_out), 32'h1);
      rd(ADDR_CAUSE, 32'h0);
      pulse(0, 1'b1, 1'b1);
      settle();
      check(32'(sleep_reset_out), 32'h0);
      rd(ADDR_CAUSE, 32'h06);
      // interrupt raise, mask and clear
      wr(ADDR_IRQ_STAT, 32'h0f);
      wr(ADDR_IRQ_MASK, 32'h01);
      rd(ADDR_IRQ_MASK, 32'h01);
      pulse(1, 1'b1, 1'b1);
      settle();
      check(32'(irq_out), 32'h0);
      pulse(0, 1'b1, 1'b1);
      settle();
      check(32'(irq_out), 32'h1);
      rd(ADDR_IRQ_STAT, 32'h03);
      wr(ADDR_IRQ_MASK, 32'h0);
      settle();
      check(32'(irq_out), 32'h0);
      wr(ADDR_IRQ_STAT, 32'h03);
      rd(ADDR_IRQ_STAT, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h0f);
      settle();
      check(32'(irq_out), 32'h0);
      wr(ADDR_CAUSE, 32'h0);
      // watchdog: frozen while disabled, sticky enable, key sequence
      tick(3);
      rd(ADDR_WATCHDOG, 32'h0);
      wr(ADDR_CONTROL, 32'hff);
      rd(ADDR_CONTROL, 32'hf0);
      wr(ADDR_CONTROL, 32'h0);
      rd(ADDR_CONTROL, 32'h10);
      tick(3);
      rd(ADDR_WATCHDOG, 32'h03);
      wr(ADDR_WATCHDOG, 32'h0a);
      wr(ADDR_WATCHDOG, 32'h03);
      rd(ADDR_WATCHDOG, 32'h0);
      tick(2);
      wr(ADDR_WATCHDOG, 32'h0a);
      wr(ADDR_WATCHDOG, 32'h05);
      wr(ADDR_WATCHDOG, 32'h03);
      rd(ADDR_WATCHDOG, 32'h02);
      tick(5);
      rd(ADDR_WATCHDOG, 32'h07);
      tick(1);
      settle();
      rd(ADDR_CAUSE, 32'h10);
      rd(ADDR_WATCHDOG, 32'h0);
      rd(ADDR_CONTROL, 32'h10);
      // power-up reset again in mid-run: cold values everywhere
      pulse(0, 1'b1, 1'b0);
      @(posedge clk_in);
      nrst_in <= 1'b0;
      #1;
      check(32'(cold_reset_out), 32'h1);
      check(32'(system_reset_out), 32'h1);
      check(32'(port_config_reset_out), 32'h1);
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      rd(ADDR_CONTROL, 32'h0);
      check(32'(cold_reset_out), 32'h0);
      rd(ADDR_WATCHDOG, 32'h0);
      rd(ADDR_CAUSE, 32'h0);
      complete_run();
   end
endmodule : tb_reset_sleep_manager
